// File: dv/bus_master_model.sv
/*
 * two-wire bus master model: drives scl, pulls sda low when asked.
 * assumes the bench resolves sda with a pull-up; scl stands still between
 * frames and each bit takes 8 system clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
	input wire logic ref_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// sda pull-down goes from a to b while scl is high, so the sda level goes from ~a to ~b
	task automatic cond(input logic a, input logic b);
		tick(1);
		sda_oe_o <= a;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_oe_o <= b;
		tick(4);
	endtask

	// also serves as repeated start, never a stop before a read
	task automatic start();
		cond(1'b0, 1'b1);
		scl_o <= 1'b0;
	endtask

	task automatic stop();
		cond(1'b1, 1'b0);
	endtask

	// sample mid-high, well clear of the device's late answer
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_oe_o <= ~b;
		tick(3);
		scl_o <= 1'b1;
		tick(2);
		r = sda_i;
		tick(2);
		scl_o <= 1'b0;
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack, r);
	endtask
endmodule // bus_master_model
`default_nettype wire

// File: dv/test_sensor_i2c_register_slave.sv
/*
 * self-checking bench for the two-wire register target port.
 * assumes the master model above and a pull-up on sda; scl is driven by the model.
 */
`timescale 1ns/10ps
`default_nettype none
module test_sensor_i2c_register_slave;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic addr_select_pin_i = 1'b0;
	logic core_powered_i = 1'b1;
	logic scl, m_oe, dut_sda, dut_oe, sda_w, busy, sel, wr_stb;
	logic [7:0] wr_idx, wr_dat;
	logic [15:0] wq[$];
	int n_fail = 0;
	int n_tests = 0;
	int oe_cnt = 0;

	always #20 ref_clk_i = ~ref_clk_i;
	// open drain: low if either party pulls
	assign sda_w = ~(m_oe | (dut_oe & ~dut_sda));

	always @(posedge ref_clk_i)
	begin
		if (wr_stb === 1'b1)
			wq.push_back({wr_idx, wr_dat});
		if (dut_oe === 1'b1)
			oe_cnt++;
	end

	bus_master_model master (.ref_clk_i(ref_clk_i), .sda_i(sda_w),
		.scl_o(scl), .sda_oe_o(m_oe));

	sensor_i2c_register_slave dut (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(dut_sda), .sda_oe_o(dut_oe),
		.addr_select_pin_i(addr_select_pin_i),
		.core_powered_i(core_powered_i), .busy_o(busy),
		.selected_o(sel), .wr_stb_o(wr_stb), .wr_index_o(wr_idx),
		.wr_data_o(wr_dat));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic complete_run();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_write();
		logic ack;
		@(posedge ref_clk_i);
		addr_select_pin_i <= 1'b1;
		master.tick(4);
		master.start();
		chk(busy, 1'b1);
		master.wr_byte(8'h3a, ack);
		chk(ack, 1'b1);
		chk(sel, 1'b1);
		master.wr_byte(8'h10, ack);
		chk(ack, 1'b1);
		master.wr_byte(8'h55, ack);
		chk(ack, 1'b1);
		master.wr_byte(8'ha3, ack);
		chk(ack, 1'b1);
		master.stop();
		chk(busy, 1'b0);
		chk(sel, 1'b0);
		chk(16'(wq.size()), 16'h0002);
		chk(wq[0], 16'h1055);
		chk(wq[1], 16'h11a3);
		wq.delete();
	endtask

	task automatic t_read();
		logic ack;
		logic [7:0] d;
		master.start();
		master.wr_byte(8'h3a, ack);
		master.wr_byte(8'h10, ack);
		chk(ack, 1'b1);
		master.start();
		master.wr_byte(8'h3b, ack);
		chk(ack, 1'b1);
		master.rd_byte(1'b1, d);
		chk(d, 8'h55);
		master.rd_byte(1'b0, d);
		chk(d, 8'ha3);
		master.tick(6);
		chk(dut_oe, 1'b0);
		master.stop();
		chk(sda_w, 1'b1);
		chk(16'(wq.size()), 16'h0000);
	endtask

	task automatic t_reserved();
		logic ack;
		logic [7:0] d;
		@(posedge ref_clk_i);
		addr_select_pin_i <= 1'b0;
		master.tick(4);
		master.start();
		master.wr_byte(8'h38, ack);
		chk(ack, 1'b1);
		master.wr_byte(8'h1c, ack);
		master.wr_byte(8'h12, ack);
		chk(ack, 1'b1);
		master.wr_byte(8'h34, ack);
		master.start();
		master.wr_byte(8'h38, ack);
		master.wr_byte(8'h07, ack);
		master.wr_byte(8'hff, ack);
		master.stop();
		chk(16'(wq.size()), 16'h0001);
		chk(wq[0], 16'h1d34);
		wq.delete();
		master.start();
		master.wr_byte(8'h38, ack);
		master.wr_byte(8'h07, ack);
		master.start();
		master.wr_byte(8'h39, ack);
		chk(ack, 1'b1);
		master.rd_byte(1'b1, d);
		chk(d, 8'h00);
		master.rd_byte(1'b0, d);
		chk(d, 8'h00);
		master.stop();
	endtask

	task automatic t_mismatch();
		logic ack;
		int n;
		master.start();
		master.wr_byte(8'h3a, ack);
		chk(ack, 1'b0);
		chk(sel, 1'b0);
		n = oe_cnt;
		master.wr_byte(8'h00, ack);
		chk(16'(oe_cnt - n), 16'h0000);
		master.stop();
		chk(16'(wq.size()), 16'h0000);
	endtask

	task automatic t_unpowered();
		logic ack;
		int n;
		@(posedge ref_clk_i);
		core_powered_i <= 1'b0;
		master.tick(4);
		n = oe_cnt;
		master.start();
		chk(busy, 1'b0);
		master.wr_byte(8'h38, ack);
		chk(ack, 1'b0);
		master.wr_byte(8'h20, ack);
		master.wr_byte(8'h66, ack);
		master.stop();
		chk(16'(oe_cnt - n), 16'h0000);
		chk(16'(wq.size()), 16'h0000);
		@(posedge ref_clk_i);
		core_powered_i <= 1'b1;
		master.tick(4);
		master.start();
		master.wr_byte(8'h38, ack);
		chk(ack, 1'b1);
		master.stop();
	endtask

	initial
	begin
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk(busy, 1'b0);
		chk(dut_oe, 1'b0);
		t_write();
		t_read();
		t_reserved();
		t_mismatch();
		t_unpowered();
		complete_run();
	end

	// whole run is near 2200 cycles; generous margin
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		n_fail++;
		complete_run();
	end
endmodule // test_sensor_i2c_register_slave
`default_nettype wire

// File: include/reg_port_if.sv
/*
 * port between the serial engine and its register memory.
 * assumes both ends share one clock; read data lag address by one edge.
 */
`timescale 1ns/10ps
`default_nettype none
interface reg_port_if #(
	parameter int AW = 8,
	parameter int DW = 8
);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport core (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface
`default_nettype wire

// File: include/sens_i2c_pkg.sv
/*
 * shared constants for the two-wire register target port.
 * assumes a 25 MHz system clock and an 8-bit register space.
 */
`default_nettype none
package sens_i2c_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int SCL_FAST_HZ = 400000;
	localparam int SCL_STD_HZ = 100000;
	// shortest bus clock period in system cycles, rounded down
	localparam int SCL_FAST_CYC = CLK_HZ / SCL_FAST_HZ;
	localparam int SCL_STD_CYC = CLK_HZ / SCL_STD_HZ;
	localparam int SYNC_STAGES = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [5:0] DEV_ADDR_HI = 6'h0e;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] MEM_RST = 8'h00;
	localparam logic [7:0] RSVD_DATA = 8'h00;
	localparam logic [7:0] RSVD_A0 = 8'h07;
	localparam logic [7:0] RSVD_A1 = 8'h08;
	localparam logic [7:0] RSVD_B_LO = 8'h19;
	localparam logic [7:0] RSVD_B_HI = 8'h1c;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_INDEX_ACK,
		ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK, ST_IGNORE
	} port_state_t;

	function automatic logic is_reserved(input logic [7:0] idx);
		is_reserved = (idx == RSVD_A0) || (idx == RSVD_A1) ||
			((idx >= RSVD_B_LO) && (idx <= RSVD_B_HI));
	endfunction
endpackage
`default_nettype wire

// File: src/level_sync.sv
/*
 * two-flop synchroniser for a group of asynchronous levels.
 * assumes the inputs are slow compared with the clock.
 */
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			meta_q <= RST;
			sync_o <= RST;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // level_sync
`default_nettype wire

// File: src/reg_space_mem.sv
/*
 * register space storage, one write and one registered read port.
 * assumes the engine keeps the read address steady while it waits.
 */
`timescale 1ns/10ps
`default_nettype none
module reg_space_mem
	import sens_i2c_pkg::*;
#(
	parameter int DEPTH = 256
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	reg_port_if.mem port
);
	logic [DATA_W-1:0] cells_q [DEPTH];

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				cells_q[i] <= MEM_RST;
		end
		else if (port.we)
			cells_q[port.waddr] <= port.wdata;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			port.rdata <= MEM_RST;
		else
			port.rdata <= cells_q[port.raddr];
	end
endmodule // reg_space_mem
`default_nettype wire

// File: src/sensor_i2c_register_slave.sv
/*
 * two-wire target port giving a bus master access to the register space.
 * assumes external pull-ups on both lines and a master that drives scl;
 * the port never stretches the clock.
 */
// Contract
// [R1] address 0011100 or 0011101 by select pin
// [R2] sda fall with scl high starts, bus busy
// [R3] sda rise with scl high ends transfer
// [R4] compare first seven bits, select on match
// [R5] eighth address bit gives direction
// [R6] receiver holds sda low in ninth clock
// [R7] transmitter releases sda in ack slot
// [R8] master uses repeated start before reading
// [R9] index write, repeated start, then read byte
// [R10] returned bytes go out msb first
// [R11] master ack advances pointer, next byte
// [R12] master nak ends read, release sda
// [R13] write stores byte at indexed register
// [R14] each written byte advances the pointer
// [R15] master ends every transfer with stop
// [R16] core unpowered: ignore bus, stay released
// [R17] lines idle high, only pulled low
// [R18] works at 100 kHz and 400 kHz
// [R19] reserved locations read as 0x00
// [R20] address mismatch: no ack, stay released
// [R21] lines synchronised, events from synced samples
`timescale 1ns/10ps
`default_nettype none
module sensor_i2c_register_slave (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_select_pin_i,
	input wire logic core_powered_i,
	output logic busy_o,
	output logic selected_o,
	output logic wr_stb_o,
	output logic [sens_i2c_pkg::ADDR_W-1:0] wr_index_o,
	output logic [sens_i2c_pkg::DATA_W-1:0] wr_data_o
);
	import sens_i2c_pkg::*;

	logic [3:0] pins_s;
	logic scl_s, sda_s, sel_s, pwr_s;
	logic scl_p_q, sda_p_q;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	port_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic ack_q;
	logic [6:0] own_addr;
	logic [7:0] rd_byte;
	logic addr_hit;

	reg_port_if #(.AW(ADDR_W), .DW(DATA_W)) mem_port ();

	// idle-high reset so no false start after reset
	level_sync #(.W(4), .RST(4'hf)) pin_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({scl_i, sda_i, addr_select_pin_i, core_powered_i}),
		.sync_o(pins_s)
	); // R21

	assign {scl_s, sda_s, sel_s, pwr_s} = pins_s;

	reg_space_mem #(.DEPTH(1 << ADDR_W)) regs (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.port(mem_port.mem)
	);

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// edges seen a few cycles late; far below a quarter fast-mode period
	assign scl_rise = scl_s & ~scl_p_q; // R18
	assign scl_fall = ~scl_s & scl_p_q; // R21
	assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // R2
	assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s; // R3

	assign own_addr = {DEV_ADDR_HI, sel_s}; // R1
	assign addr_hit = (rx_q[7:1] == own_addr); // R4
	assign rd_byte = is_reserved(ptr_q) ? RSVD_DATA : mem_port.rdata; // R19

	// memory read follows the pointer every cycle, so data is ready early
	assign mem_port.raddr = ptr_q;

	// sequencing; a repeated start simply restarts address reception
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || !pwr_s)
			state_q <= ST_IDLE; // R16
		else if (stop_ev)
			state_q <= ST_IDLE; // R3
		else if (start_ev)
			state_q <= ST_ADDR; // R2 R8
		else if (scl_fall)
		begin
			case (state_q)
				ST_ADDR:
					if (cnt_q == BYTE_BITS)
						state_q <= addr_hit ? ST_ADDR_ACK : ST_IGNORE; // R20
				ST_INDEX:
					if (cnt_q == BYTE_BITS)
						state_q <= ST_INDEX_ACK;
				ST_WRITE:
					if (cnt_q == BYTE_BITS)
						state_q <= ST_WRITE_ACK;
				ST_ADDR_ACK:
					state_q <= rw_q ? ST_READ : ST_INDEX; // R9
				ST_INDEX_ACK, ST_WRITE_ACK:
					state_q <= ST_WRITE; // R13
				ST_READ:
					if (cnt_q == BYTE_BITS)
						state_q <= ST_READ_ACK;
				ST_READ_ACK:
					state_q <= ack_q ? ST_READ : ST_IGNORE; // R11 R12
				default:
					state_q <= state_q;
			endcase
		end
	end

	// bit counter: receive counts rises, transmit counts falls
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || start_ev)
			cnt_q <= CNT_RST;
		// a write goes on to receive the index, counted from zero
		else if (scl_fall && state_q == ST_ADDR_ACK)
			cnt_q <= rw_q ? 4'h1 : CNT_RST; // R9 R13
		else if (scl_fall && state_q == ST_READ_ACK)
			cnt_q <= 4'h1;
		else if (scl_fall && (state_q == ST_INDEX_ACK ||
			state_q == ST_WRITE_ACK))
			cnt_q <= CNT_RST;
		else if (scl_fall && state_q == ST_READ && cnt_q != BYTE_BITS)
			cnt_q <= cnt_q + 4'h1;
		else if (scl_rise && (state_q == ST_ADDR ||
			state_q == ST_INDEX || state_q == ST_WRITE))
			cnt_q <= cnt_q + 4'h1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			rx_q <= 8'h00;
		else if (scl_rise && (state_q == ST_ADDR ||
			state_q == ST_INDEX || state_q == ST_WRITE))
			rx_q <= {rx_q[6:0], sda_s};
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			rw_q <= 1'b0;
		else if (scl_fall && state_q == ST_ADDR && cnt_q == BYTE_BITS)
			rw_q <= rx_q[0]; // R5
	end

	// master's answer sampled while scl is high
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			ack_q <= 1'b0;
		else if (scl_rise && state_q == ST_READ_ACK)
			ack_q <= ~sda_s;
	end

	// pointer: index load, post-write and post-ack increments
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			ptr_q <= PTR_RST;
		else if (scl_fall && state_q == ST_INDEX && cnt_q == BYTE_BITS)
			ptr_q <= rx_q;
		else if (scl_fall && state_q == ST_WRITE && cnt_q == BYTE_BITS)
			ptr_q <= ptr_q + 8'h01; // R14
		else if (scl_rise && state_q == ST_READ_ACK && !sda_s)
			ptr_q <= ptr_q + 8'h01; // R11
	end

	// reserved locations are not writable
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			mem_port.we <= 1'b0;
			mem_port.waddr <= PTR_RST;
			mem_port.wdata <= MEM_RST;
		end
		else
		begin
			mem_port.we <= scl_fall && state_q == ST_WRITE &&
				cnt_q == BYTE_BITS && !is_reserved(ptr_q); // R13
			mem_port.waddr <= ptr_q;
			mem_port.wdata <= rx_q;
		end
	end

	// transmit shifter loads at the fall that ends an ack slot
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			tx_q <= 8'h00;
		else if (scl_fall && ((state_q == ST_ADDR_ACK && rw_q) ||
			(state_q == ST_READ_ACK && ack_q)))
			tx_q <= rd_byte; // R9 R19
		else if (scl_fall && state_q == ST_READ)
			tx_q <= {tx_q[6:0], 1'b0}; // R10
	end

	// open drain: the pin level is only ever pulled low
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0; // R17
	end

	// sda drive; changes only after a falling scl edge, on a bus event or on core power loss
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || !pwr_s || stop_ev || start_ev)
			sda_oe_o <= 1'b0; // R3 R16
		else if (scl_fall)
		begin
			case (state_q)
				ST_ADDR:
					sda_oe_o <= (cnt_q == BYTE_BITS) && addr_hit; // R6 R20
				ST_INDEX, ST_WRITE:
					sda_oe_o <= (cnt_q == BYTE_BITS); // R6
				ST_ADDR_ACK:
					sda_oe_o <= rw_q && !rd_byte[7]; // R10
				ST_READ:
					sda_oe_o <= (cnt_q != BYTE_BITS) && !tx_q[6]; // R7 R10
				ST_READ_ACK:
					sda_oe_o <= ack_q && !rd_byte[7]; // R12
				default:
					sda_oe_o <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || !pwr_s)
			busy_o <= 1'b0;
		else if (stop_ev)
			busy_o <= 1'b0;
		else if (start_ev)
			busy_o <= 1'b1; // R2
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || !pwr_s || stop_ev || start_ev)
			selected_o <= 1'b0;
		else if (scl_fall && state_q == ST_ADDR && cnt_q == BYTE_BITS)
			selected_o <= addr_hit; // R4
	end

	// mirror of stored writes for the sensor core
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			wr_stb_o <= 1'b0;
			wr_index_o <= PTR_RST;
			wr_data_o <= MEM_RST;
		end
		else
		begin
			wr_stb_o <= mem_port.we;
			wr_index_o <= mem_port.waddr;
			wr_data_o <= mem_port.wdata;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	addr_ack_a: assert property ( // R1
		(scl_fall && state_q == ST_ADDR && cnt_q == BYTE_BITS && addr_hit &&
			pwr_s && !start_ev && !stop_ev) |=> sda_oe_o && selected_o)
		else $error("matching address not acknowledged");
	mismatch_free_a: assert property ( // R20
		state_q == ST_IGNORE |-> !sda_oe_o)
		else $error("sda driven while ignoring the bus");
	addr_miss_a: assert property ( // R20
		(scl_fall && state_q == ST_ADDR && cnt_q == BYTE_BITS && !addr_hit &&
			pwr_s && !start_ev && !stop_ev) |=>
			state_q == ST_IGNORE && !sda_oe_o && !selected_o)
		else $error("foreign address acknowledged");
	start_busy_a: assert property ( // R2
		(start_ev && pwr_s) |=> busy_o && state_q == ST_ADDR && cnt_q == 0)
		else $error("start not taken");
	stop_end_a: assert property ( // R3
		stop_ev |=> state_q == ST_IDLE && !sda_oe_o && !busy_o)
		else $error("stop did not end transfer");
	ack_hold_a: assert property ( // R6
		(state_q == ST_WRITE_ACK && scl_s && $past(scl_s) && pwr_s &&
			!stop_ev && !start_ev) |=> sda_oe_o)
		else $error("ack released during high phase");
	master_ack_free_a: assert property ( // R7
		(state_q == ST_READ_ACK) |-> !sda_oe_o)
		else $error("sda driven during master ack slot");
	msb_first_a: assert property ( // R10
		(scl_fall && state_q == ST_ADDR_ACK && rw_q && pwr_s &&
			!start_ev && !stop_ev) |=> sda_oe_o == !$past(rd_byte[7]))
		else $error("first read bit is not the msb");
	ptr_step_a: assert property ( // R11
		(scl_rise && state_q == ST_READ_ACK && !sda_s && pwr_s)
			|=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer not advanced on master ack");
	nak_release_a: assert property ( // R12
		(scl_fall && state_q == ST_READ_ACK && !ack_q && pwr_s &&
			!start_ev && !stop_ev) |=> state_q == ST_IGNORE ##1 !sda_oe_o)
		else $error("read continued after nak");
	write_store_a: assert property ( // R13
		(scl_fall && state_q == ST_WRITE && cnt_q == BYTE_BITS && pwr_s &&
			!start_ev && !stop_ev && !is_reserved(ptr_q)) |=>
			mem_port.we && mem_port.wdata == $past(rx_q) ##1 wr_stb_o)
		else $error("written byte not stored");
	power_off_a: assert property ( // R16
		!pwr_s |=> !sda_oe_o && !busy_o)
		else $error("bus disturbed while core unpowered");
	reserved_zero_a: assert property ( // R19
		(scl_fall && state_q == ST_READ_ACK && ack_q && is_reserved(ptr_q) &&
			pwr_s && !start_ev && !stop_ev) |=> tx_q == RSVD_DATA)
		else $error("reserved location read non-zero");
	pull_low_a: assert property ( // R17
		sda_oe_o |-> sda_o == 1'b0)
		else $error("sda driven high");
endmodule // sensor_i2c_register_slave
`default_nettype wire
